// File: nbe_pkg.sv
`default_nettype none

package nbe_pkg;

    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] NBE_OFS_CONTROL    = 8'h00;
    localparam logic [7:0] NBE_OFS_FLAGS      = 8'h04;
    localparam logic [7:0] NBE_OFS_RESET_VEC  = 8'h08;
    localparam logic [7:0] NBE_OFS_NMI_VEC    = 8'h0c;
    localparam logic [7:0] NBE_OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] NBE_OFS_IRQ_MASK   = 8'h14;

    // field positions of nvm_error_control_word
    localparam int NBE_BIT_URE = 0;
    localparam int NBE_BIT_UIE = 1;
    localparam int NBE_BIT_CIE = 2;

    // field positions of nvm_error_flag_word
    localparam int NBE_BIT_CFLAG = 0;
    localparam int NBE_BIT_UFLAG = 1;

    // field positions of the interrupt status and mask words
    localparam int NBE_BIT_EV_CORR  = 0;
    localparam int NBE_BIT_EV_UNCOR = 1;
    localparam int NBE_BIT_EV_SPUR  = 2;

    // reset values
    localparam logic [2:0] NBE_CONTROL_RESET = 3'h0;
    localparam logic [1:0] NBE_FLAGS_RESET   = 2'h0;
    localparam logic [2:0] NBE_IRQ_RESET     = 3'h0;
    localparam logic [7:0] NBE_VEC_RESET     = 8'h00;

    // vector codes; the nonzero values are arbitrary
    localparam logic [7:0] NBE_RSV_NONE          = 8'h00;
    localparam logic [7:0] NBE_RSV_UNCORRECTABLE = 8'h1a;
    localparam logic [7:0] NBE_NMI_NONE          = 8'h00;
    localparam logic [7:0] NBE_NMI_UNCORRECTABLE = 8'h02;
    localparam logic [7:0] NBE_NMI_CORRECTABLE   = 8'h04;

    typedef struct packed {
        logic correctable_interrupt_enable;
        logic uncorrectable_interrupt_enable;
        logic uncorrectable_reset_enable;
    } nbe_control_type;

    typedef struct packed {
        logic uncorrectable_error_flag;
        logic correctable_error_flag;
    } nbe_flag_type;

    typedef struct packed {
        logic spurious_reset;
        logic uncorrectable;
        logic correctable;
    } nbe_event_type;

    typedef enum logic {
        NBE_RUN,
        NBE_WAKE_WINDOW
    } nbe_state_type;

endpackage

`default_nettype wire

// File: nbe_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module nbe_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign o_sync = stage2_reg;

endmodule

`default_nettype wire

// File: nbe_nvm_error_report.sv
// Overview of operation
// (RQ1) an uncorrectable bit error detected in the memory sets the uncorrectable error flag.
// (RQ2) on affected revisions an uncorrectable error raises no nmi outside the wake window.
// (RQ3) software wanting uncorrectable reports enables reset only and checks the flag after reset.
// (RQ4) with reset enabled, a spurious error at a high main clock rate during nvm execution resets.
// (RQ5) that spurious reset writes reset source 0x00 and leaves the uncorrectable flag clear.
// (RQ6) software may ignore a reset with source 0 or keep the main clock at or below 12 MHz.
// (RQ7) clearing reset enable stops the spurious reset but also loses the uncorrectable nmi; here it drops the uncorrectable reset, not the nmi.
// (RQ8) after a sleep wake-up, a reported uncorrectable error with reset enabled resets with its code.
// (RQ9) after a sleep wake-up, an uncorrectable error with its interrupt enabled raises an nmi.
// (RQ10) after a sleep wake-up, a correctable error with its interrupt enabled raises an nmi.
// (RQ11) software clears all three enables before entering sleep modes 1 to 4.
// (RQ12) after wake-up software clears both flags and restores enables after the first valid access.
// (RQ13) both error flags stay set until software clears them; a new detection keeps them set.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module nbe_nvm_error_report
    import nbe_pkg::*;
#(
    parameter bit AFFECTED_REVISION = 1'b1
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    input  wire logic        i_correctable_detect,
    input  wire logic        i_uncorrectable_detect,
    input  wire logic        i_spurious_detect,
    input  wire logic        i_nvm_exec,
    input  wire logic        i_high_clock_rate,
    input  wire logic        i_wake,
    input  wire logic        i_nvm_access_done,
    output logic      [31:0] o_rdata,
    output logic             o_puc_request,
    output logic             o_nmi_request,
    output logic             o_irq,
    output logic             o_wake_window
);

    nbe_control_type control_reg;
    nbe_control_type control_next;
    nbe_flag_type    flag_reg;
    nbe_flag_type    flag_next;
    nbe_event_type   irq_status_reg;
    nbe_event_type   irq_status_next;
    nbe_event_type   irq_mask_reg;
    nbe_event_type   irq_mask_next;
    nbe_state_type   state_reg;
    nbe_state_type   state_next;
    logic [7:0]      reset_vector_reg;
    logic [7:0]      reset_vector_next;
    logic [7:0]      nmi_vector_reg;
    logic [7:0]      nmi_vector_next;
    logic [31:0]     rdata_reg;
    logic [31:0]     rdata_next;
    logic            puc_reg;
    logic            nmi_reg;
    logic            irq_reg;

    logic high_rate_sync;

    // main clock source rate strap comes from the clock system pin
    nbe_sync2 #(
        .WIDTH (1)
    ) u_rate_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_high_clock_rate),
        .o_sync  (high_rate_sync)
    );

    // bus decode
    wire wr_control    = i_write && (i_addr == NBE_OFS_CONTROL);
    wire wr_flags      = i_write && (i_addr == NBE_OFS_FLAGS);
    wire wr_reset_vec  = i_write && (i_addr == NBE_OFS_RESET_VEC);
    wire wr_nmi_vec    = i_write && (i_addr == NBE_OFS_NMI_VEC);
    wire wr_irq_status = i_write && (i_addr == NBE_OFS_IRQ_STATUS);
    wire wr_irq_mask   = i_write && (i_addr == NBE_OFS_IRQ_MASK);

    wire in_wake_window = (state_reg == NBE_WAKE_WINDOW);

    // reset paths
    wire uncorr_reset = i_uncorrectable_detect
                        && control_reg.uncorrectable_reset_enable;              // [RQ8]
    wire spurious_hit = AFFECTED_REVISION && i_spurious_detect && i_nvm_exec
                        && high_rate_sync
                        && control_reg.uncorrectable_reset_enable;              // [RQ4]

    // nmi paths: with AFFECTED_REVISION set, the uncorrectable one only works inside the wake window
    wire uncorr_nmi_allowed = control_reg.uncorrectable_interrupt_enable
                              && (!AFFECTED_REVISION || in_wake_window);        // [RQ2] [RQ9]
    wire uncorr_nmi = i_uncorrectable_detect && uncorr_nmi_allowed;
    wire corr_nmi   = i_correctable_detect
                      && control_reg.correctable_interrupt_enable;              // [RQ10]

    // hardware events for the interrupt status word
    wire [2:0] event_set = {spurious_hit, i_uncorrectable_detect, i_correctable_detect};

    // wake window tracking
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NBE_RUN: begin
                if (i_wake) begin
                    state_next = NBE_WAKE_WINDOW;
                end
            end
            NBE_WAKE_WINDOW: begin
                if (i_nvm_access_done && !i_wake) begin
                    state_next = NBE_RUN;
                end
            end
            default: begin
                state_next = NBE_RUN;
            end
        endcase
    end

    // control word
    assign control_next = wr_control ? nbe_control_type'(i_wdata[2:0]) : control_reg;

    // sticky flags, write one to clear, set wins over clear
    assign flag_next.uncorrectable_error_flag =
        i_uncorrectable_detect
        || (flag_reg.uncorrectable_error_flag
            && !(wr_flags && i_wdata[NBE_BIT_UFLAG]));                         // [RQ1] [RQ13]
    assign flag_next.correctable_error_flag =
        i_correctable_detect
        || (flag_reg.correctable_error_flag
            && !(wr_flags && i_wdata[NBE_BIT_CFLAG]));                         // [RQ13]

    // reset source vector: a real error wins over a spurious one
    assign reset_vector_next = uncorr_reset   ? NBE_RSV_UNCORRECTABLE :       // [RQ8]
                               spurious_hit   ? NBE_RSV_NONE :                // [RQ5]
                               wr_reset_vec   ? NBE_VEC_RESET :
                               reset_vector_reg;

    // system nmi vector: uncorrectable takes priority
    assign nmi_vector_next = uncorr_nmi ? NBE_NMI_UNCORRECTABLE :
                             corr_nmi   ? NBE_NMI_CORRECTABLE :
                             wr_nmi_vec ? NBE_NMI_NONE :
                             nmi_vector_reg;

    // interrupt status, write one to clear, set wins
    assign irq_status_next = nbe_event_type'(event_set
        | (irq_status_reg & ~({3{wr_irq_status}} & i_wdata[2:0])));
    assign irq_mask_next = wr_irq_mask ? nbe_event_type'(i_wdata[2:0]) : irq_mask_reg;

    // read data mux; unmapped addresses read zero
    wire [31:0] rd_control    = {29'h0, control_reg};
    wire [31:0] rd_flags      = {30'h0, flag_reg};
    wire [31:0] rd_reset_vec  = {24'h0, reset_vector_reg};
    wire [31:0] rd_nmi_vec    = {24'h0, nmi_vector_reg};
    wire [31:0] rd_irq_status = {29'h0, irq_status_reg};
    wire [31:0] rd_irq_mask   = {29'h0, irq_mask_reg};
    wire [31:0] rd_mux =
        (i_addr == NBE_OFS_CONTROL)    ? rd_control :
        (i_addr == NBE_OFS_FLAGS)      ? rd_flags :
        (i_addr == NBE_OFS_RESET_VEC)  ? rd_reset_vec :
        (i_addr == NBE_OFS_NMI_VEC)    ? rd_nmi_vec :
        (i_addr == NBE_OFS_IRQ_STATUS) ? rd_irq_status :
        (i_addr == NBE_OFS_IRQ_MASK)   ? rd_irq_mask :
        32'h0;
    assign rdata_next = i_read ? rd_mux : 32'h0;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg        <= NBE_RUN;
            control_reg      <= NBE_CONTROL_RESET;
            flag_reg         <= NBE_FLAGS_RESET;
            irq_status_reg   <= NBE_IRQ_RESET;
            irq_mask_reg     <= NBE_IRQ_RESET;
            reset_vector_reg <= NBE_VEC_RESET;
            nmi_vector_reg   <= NBE_VEC_RESET;
        end else begin
            state_reg        <= state_next;
            control_reg      <= control_next;
            flag_reg         <= flag_next;
            irq_status_reg   <= irq_status_next;
            irq_mask_reg     <= irq_mask_next;
            reset_vector_reg <= reset_vector_next;
            nmi_vector_reg   <= nmi_vector_next;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 32'h0;
            puc_reg   <= 1'b0;
            nmi_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            puc_reg   <= uncorr_reset || spurious_hit;                          // [RQ4] [RQ8]
            nmi_reg   <= uncorr_nmi || corr_nmi;                                // [RQ9] [RQ10]
            irq_reg   <= |(irq_status_next & irq_mask_next);
        end
    end

    assign o_rdata       = rdata_reg;
    assign o_puc_request = puc_reg;
    assign o_nmi_request = nmi_reg;
    assign o_irq         = irq_reg;
    assign o_wake_window = (state_reg == NBE_WAKE_WINDOW);

    // checks

    property p_uncorr_flag_set;
        @(posedge i_clock) disable iff (i_rst)
        i_uncorrectable_detect |=> flag_reg.uncorrectable_error_flag;
    endproperty
    a_uncorr_flag_set: assert property (p_uncorr_flag_set) // [RQ1]
        else $error("uncorrectable flag not set after detection");

    property p_no_uncorr_nmi;
        @(posedge i_clock) disable iff (i_rst)
        (AFFECTED_REVISION && !in_wake_window && i_uncorrectable_detect)
        |=> !(o_nmi_request && nmi_vector_reg == NBE_NMI_UNCORRECTABLE);
    endproperty
    a_no_uncorr_nmi: assert property (p_no_uncorr_nmi) // [RQ2]
        else $error("uncorrectable nmi raised outside wake window");

    property p_spurious_reset;
        @(posedge i_clock) disable iff (i_rst)
        (i_spurious_detect && i_nvm_exec && high_rate_sync
         && control_reg.uncorrectable_reset_enable && AFFECTED_REVISION)
        |=> o_puc_request ##1 (!o_puc_request || $past(spurious_hit) || $past(uncorr_reset));
    endproperty
    a_spurious_reset: assert property (p_spurious_reset) // [RQ4]
        else $error("spurious detection did not request a reset");

    property p_spurious_vector;
        @(posedge i_clock) disable iff (i_rst)
        (spurious_hit && !i_uncorrectable_detect && !wr_flags)
        |=> (reset_vector_reg == NBE_RSV_NONE)
            && (flag_reg.uncorrectable_error_flag
                == $past(flag_reg.uncorrectable_error_flag));
    endproperty
    a_spurious_vector: assert property (p_spurious_vector) // [RQ5]
        else $error("spurious reset changed vector or flag");

    property p_uncorr_reset;
        @(posedge i_clock) disable iff (i_rst)
        (i_uncorrectable_detect && control_reg.uncorrectable_reset_enable)
        |=> o_puc_request && (reset_vector_reg == NBE_RSV_UNCORRECTABLE);
    endproperty
    a_uncorr_reset: assert property (p_uncorr_reset) // [RQ8]
        else $error("uncorrectable error reset missing or wrong code");

    property p_wake_uncorr_nmi;
        @(posedge i_clock) disable iff (i_rst)
        (in_wake_window && control_reg.uncorrectable_interrupt_enable
         && i_uncorrectable_detect)
        |=> o_nmi_request && (nmi_vector_reg == NBE_NMI_UNCORRECTABLE);
    endproperty
    a_wake_uncorr_nmi: assert property (p_wake_uncorr_nmi) // [RQ9]
        else $error("uncorrectable nmi missing in wake window");

    property p_corr_nmi;
        @(posedge i_clock) disable iff (i_rst)
        (control_reg.correctable_interrupt_enable && i_correctable_detect
         && !uncorr_nmi)
        |=> o_nmi_request && (nmi_vector_reg == NBE_NMI_CORRECTABLE);
    endproperty
    a_corr_nmi: assert property (p_corr_nmi) // [RQ10]
        else $error("correctable nmi missing or wrong code");

    property p_flag_sticky;
        @(posedge i_clock) disable iff (i_rst)
        (flag_reg.uncorrectable_error_flag
         && !(wr_flags && i_wdata[NBE_BIT_UFLAG]))
        |=> flag_reg.uncorrectable_error_flag [*2]
            or (flag_reg.uncorrectable_error_flag ##1
                $past(wr_flags) || !flag_reg.uncorrectable_error_flag);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [RQ13]
        else $error("uncorrectable flag dropped without a clear");

    property p_corr_flag_sticky;
        @(posedge i_clock) disable iff (i_rst)
        (flag_reg.correctable_error_flag && !(wr_flags && i_wdata[NBE_BIT_CFLAG]))
        |=> flag_reg.correctable_error_flag;
    endproperty
    a_corr_flag_sticky: assert property (p_corr_flag_sticky) // [RQ13]
        else $error("correctable flag dropped without a clear");

    property p_wake_window_ends;
        @(posedge i_clock) disable iff (i_rst)
        (in_wake_window && i_nvm_access_done && !i_wake) |=> !o_wake_window;
    endproperty
    a_wake_window_ends: assert property (p_wake_window_ends) // [RQ9]
        else $error("wake window did not close after first access");

endmodule

`default_nettype wire

// File: nbe_sysctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module nbe_sysctl_model (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_puc_request,
    input  wire logic       i_nmi_request,
    output logic      [7:0] o_puc_count,
    output logic      [7:0] o_nmi_count
);
    // counts requests so the bench can confirm none were lost or doubled
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_puc_count <= 8'h00;
            o_nmi_count <= 8'h00;
        end else begin
            if (i_puc_request) begin
                o_puc_count <= o_puc_count + 8'h01;
            end
            if (i_nmi_request) begin
                o_nmi_count <= o_nmi_count + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// File: nbe_nvm_error_report_tb.sv
`timescale 1ns/1ps
`default_nettype none

module nbe_nvm_error_report_tb;
    import nbe_pkg::*;
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        cdet;
    logic        udet;
    logic        sdet;
    logic        exec;
    logic        hirate;
    logic        wake;
    logic        acc_done;
    logic [31:0] rdata;
    logic        power_up_clear_reset;
    logic        nmi;
    logic        irq;
    logic        win;
    logic [7:0]  puc_seen;
    logic [7:0]  nmi_seen;
    int          fail_count;
    int          tests_run;
    int          exp_puc;
    int          exp_nmi;
    logic [2:0]  ctl;
    logic [2:0]  msk;
    logic [1:0]  cu;
    logic [1:0]  req;
    logic [1:0]  fl;
    logic [2:0]  st;

    nbe_nvm_error_report dut_u (
        .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_write(wr),
        .i_read(rd), .i_correctable_detect(cdet), .i_uncorrectable_detect(udet),
        .i_spurious_detect(sdet), .i_nvm_exec(exec), .i_high_clock_rate(hirate),
        .i_wake(wake), .i_nvm_access_done(acc_done), .o_rdata(rdata),
        .o_puc_request(power_up_clear_reset), .o_nmi_request(nmi), .o_irq(irq), .o_wake_window(win)
    );

    nbe_sysctl_model model_u (
        .i_clock(clock), .i_rst(rst), .i_puc_request(power_up_clear_reset), .i_nmi_request(nmi),
        .o_puc_count(puc_seen), .o_nmi_count(nmi_seen)
    );

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        chk_word(rdata, exp);
    endtask

    // one-cycle detection, then requests must appear for exactly one cycle
    task automatic fire(input logic [2:0] ev, input logic ep, input logic en);
        @(posedge clock);
        {sdet, udet, cdet} <= ev;
        @(posedge clock);
        {sdet, udet, cdet} <= 3'h0;
        #1;
        chk_bit(power_up_clear_reset, ep);
        chk_bit(nmi, en);
        exp_puc += ep;
        exp_nmi += en;
        @(posedge clock);
        #1;
        chk_bit(power_up_clear_reset, 1'b0);
        chk_bit(nmi, 1'b0);
    endtask

    // returns {puc, nmi}; ctl is {cie, uie, ure}, cu is {uncorrectable, correctable}
    function automatic logic [1:0] expect_req(input logic [2:0] c, input logic [1:0] e,
                                              input logic w);
        expect_req[1] = e[1] & c[0];
        expect_req[0] = (e[1] & c[1] & w) | (e[0] & c[2]);
    endfunction

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        #(20 * 20000);
        fail_count++;
        close_out();
    end

    initial begin
        {addr, wdata, wr, rd, cdet, udet, sdet, exec, hirate, wake, acc_done} = '0;
        {fail_count, tests_run, exp_puc, exp_nmi} = '0;
        rst = 1'b1;
        void'($urandom(32'h1431));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) read_chk(a[7:0], 32'h0);
        chk_bit(win, 1'b0);
        bus_write(NBE_OFS_CONTROL, 32'h2);
        fire(3'b010, 1'b0, 1'b0);
        read_chk(NBE_OFS_NMI_VEC, 32'h0);
        read_chk(NBE_OFS_FLAGS, 32'h2);
        fire(3'b001, 1'b0, 1'b0);
        fire(3'b010, 1'b0, 1'b0);
        read_chk(NBE_OFS_FLAGS, 32'h3);
        bus_write(NBE_OFS_FLAGS, 32'h1);
        read_chk(NBE_OFS_FLAGS, 32'h2);
        bus_write(NBE_OFS_FLAGS, 32'h2);
        bus_write(NBE_OFS_CONTROL, 32'h1);
        fire(3'b010, 1'b1, 1'b0);
        read_chk(NBE_OFS_RESET_VEC, {24'h0, NBE_RSV_UNCORRECTABLE});
        read_chk(NBE_OFS_FLAGS, 32'h2);
        bus_write(NBE_OFS_FLAGS, 32'h3);
        bus_write(NBE_OFS_IRQ_STATUS, 32'h7);
        @(posedge clock);
        exec   <= 1'b1;
        hirate <= 1'b1;
        repeat (4) @(posedge clock);
        fire(3'b100, 1'b1, 1'b0);
        read_chk(NBE_OFS_RESET_VEC, {24'h0, NBE_RSV_NONE});
        read_chk(NBE_OFS_FLAGS, 32'h0);
        read_chk(NBE_OFS_IRQ_STATUS, 32'h4);
        @(posedge clock);
        hirate <= 1'b0;
        repeat (4) @(posedge clock);
        fire(3'b100, 1'b0, 1'b0);
        @(posedge clock);
        hirate <= 1'b1;
        exec   <= 1'b0;
        repeat (4) @(posedge clock);
        fire(3'b100, 1'b0, 1'b0);
        @(posedge clock);
        exec <= 1'b1;
        bus_write(NBE_OFS_CONTROL, 32'h2);
        fire(3'b100, 1'b0, 1'b0);
        fire(3'b010, 1'b0, 1'b0);
        @(posedge clock);
        exec <= 1'b0;
        bus_write(NBE_OFS_CONTROL, 32'h0);
        @(posedge clock);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        #1;
        chk_bit(win, 1'b1);
        bus_write(NBE_OFS_CONTROL, 32'h6);
        fire(3'b010, 1'b0, 1'b1);
        read_chk(NBE_OFS_NMI_VEC, {24'h0, NBE_NMI_UNCORRECTABLE});
        bus_write(NBE_OFS_NMI_VEC, 32'h0);
        fire(3'b001, 1'b0, 1'b1);
        read_chk(NBE_OFS_NMI_VEC, {24'h0, NBE_NMI_CORRECTABLE});
        bus_write(NBE_OFS_CONTROL, 32'h1);
        fire(3'b010, 1'b1, 1'b0);
        read_chk(NBE_OFS_RESET_VEC, {24'h0, NBE_RSV_UNCORRECTABLE});
        bus_write(NBE_OFS_FLAGS, 32'h3);
        read_chk(NBE_OFS_FLAGS, 32'h0);
        @(posedge clock);
        acc_done <= 1'b1;
        @(posedge clock);
        acc_done <= 1'b0;
        #1;
        chk_bit(win, 1'b0);
        bus_write(NBE_OFS_CONTROL, 32'h2);
        fire(3'b010, 1'b0, 1'b0);
        bus_write(NBE_OFS_FLAGS, 32'h3);
        bus_write(NBE_OFS_IRQ_STATUS, 32'h7);
        fl = 2'h0;
        st = 3'h0;
        for (int i = 0; i < 40; i++) begin
            ctl = 3'($urandom);
            msk = 3'($urandom);
            cu  = ($urandom % 2) ? 2'b10 : 2'b01;
            req = expect_req(ctl, cu, 1'b0);
            fl  = fl | cu;
            st  = st | {1'b0, cu};
            bus_write(NBE_OFS_CONTROL, {29'h0, ctl});
            bus_write(NBE_OFS_IRQ_MASK, {29'h0, msk});
            fire({1'b0, cu}, req[1], req[0]);
            read_chk(NBE_OFS_FLAGS, {30'h0, fl});
            chk_bit(irq, |(st & msk));
            if (i % 8 == 7) begin
                bus_write(NBE_OFS_FLAGS, 32'h3);
                bus_write(NBE_OFS_IRQ_STATUS, 32'h7);
                fl = 2'h0;
                st = 3'h0;
            end
        end
        chk_word({24'h0, puc_seen}, 32'(exp_puc));
        chk_word({24'h0, nmi_seen}, 32'(exp_nmi));
        close_out();
    end
endmodule

`default_nettype wire
